// [design/ccr_core_clock_reset.sv]
// Operation
// - The ratio-select pins choose whether the core runs from the PLL or the reference clock.
// - The start-up core frequency comes from the ratio-select pins sampled after reset.
// - After core reset, software may rewrite PLL multiplier and divider in the control register.
// - Control bit 12 picks reset-out or PLL clock on the shared pin, reset-out by default.
// - With reset-out picked, the shared pin shows the internal core reset state.
// - Fetch from the reset vector starts only after 4096 reference cycles of PLL lock wait.
// - Ratio pins decode 00 to 3:1, 01 to 16:1, 10 to 8:1, and 11 is reserved.

`default_nettype none

`include "ccr_map.svh"

module ccr_core_clock_reset (
    // Reference clock, reset, enable
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          ce_i,
    // Pins
    input  wire logic [1:0]    ratio_select_pins_i,
    input  wire logic          pll_clock_level_i,
    // Core control
    output logic               core_reset_n_o,
    output logic               fetch_start_o,
    output logic               core_clk_from_pll_o,
    output logic [5:0]         pll_mult_o,
    output logic [1:0]         pll_div_o,
    output logic               reset_out_pin_o,
    // AXI4-Lite write
    input  wire logic [3:0]    s_axi_awaddr_i,
    input  wire logic          s_axi_awvalid_i,
    output logic               s_axi_awready_o,
    input  wire logic [31:0]   s_axi_wdata_i,
    input  wire logic [3:0]    s_axi_wstrb_i,
    input  wire logic          s_axi_wvalid_i,
    output logic               s_axi_wready_o,
    output logic [1:0]         s_axi_bresp_o,
    output logic               s_axi_bvalid_o,
    input  wire logic          s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [3:0]    s_axi_araddr_i,
    input  wire logic          s_axi_arvalid_i,
    output logic               s_axi_arready_o,
    output logic [31:0]        s_axi_rdata_o,
    output logic [1:0]         s_axi_rresp_o,
    output logic               s_axi_rvalid_o,
    input  wire logic          s_axi_rready_i
);

    logic                      rst_meta_q;
    logic                      rst_n_q;
    ccr_pkg::ccr_state_type    state_q;
    logic [12:0]               lock_cnt_q;
    logic [1:0]                ratio_q;
    logic [31:0]               ctl_q;
    logic                      core_reset_n_q;
    logic                      fetch_q;
    logic                      src_pll_q;
    logic [5:0]                mult_q;
    logic [1:0]                div_q;
    logic                      pin_q;
    logic                      wr_en;
    ccr_pkg::ccr_wreq_type     wr_req;
    logic                      wr_ok;
    logic [3:0]                rd_addr;
    logic [31:0]               rd_data;
    logic                      rd_ok;
    logic [31:0]               strb_mask;
    logic                      lock_done;

    // ------------------------------
    // Reset release
    // ------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------
    // Start-up sequencer
    // ------------------------------
    assign lock_done = (lock_cnt_q == `CCR_LOCK_CYCLES - 13'h0001);

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q    <= ccr_pkg::ST_HOLD;
            lock_cnt_q <= 13'h0000;
        end else if (ce_i) begin
            case (state_q)
                ccr_pkg::ST_HOLD: begin
                    state_q    <= ccr_pkg::ST_LOCK;
                    lock_cnt_q <= 13'h0000;
                end
                ccr_pkg::ST_LOCK: begin
                    if (lock_done) begin
                        state_q <= ccr_pkg::ST_RUN;
                    end else begin
                        lock_cnt_q <= lock_cnt_q + 13'h0001;
                    end
                end
                ccr_pkg::ST_RUN: begin
                    state_q <= ccr_pkg::ST_RUN;
                end
                default: begin
                    state_q <= ccr_pkg::ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            core_reset_n_q <= 1'b0;
            fetch_q        <= 1'b0;
        end else if (ce_i) begin
            fetch_q        <= (state_q == ccr_pkg::ST_LOCK) && lock_done;
            core_reset_n_q <= core_reset_n_q ||
                              ((state_q == ccr_pkg::ST_LOCK) && lock_done);
        end
    end

    // ------------------------------
    // Ratio sampling
    // ------------------------------
    // capture pins after release
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ratio_q <= `CCR_RATIO_3_1;
        end else if (ce_i && state_q == ccr_pkg::ST_HOLD) begin
            ratio_q <= ratio_select_pins_i;
        end
    end

    // ------------------------------
    // Control register
    // ------------------------------
    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign strb_mask[8*b +: 8] = {8{wr_req.strb[b]}};
    end

    assign wr_ok = (wr_req.addr == `CCR_CTL_OFFSET);

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctl_q <= `CCR_CTL_RESET;
        end else if (ce_i) begin
            if (state_q == ccr_pkg::ST_HOLD) begin
                case (ratio_select_pins_i)
                    `CCR_RATIO_3_1:  ctl_q[`CCR_MULT_MSB:`CCR_MULT_LSB] <= `CCR_MULT_3;
                    `CCR_RATIO_16_1: ctl_q[`CCR_MULT_MSB:`CCR_MULT_LSB] <= `CCR_MULT_16;
                    `CCR_RATIO_8_1:  ctl_q[`CCR_MULT_MSB:`CCR_MULT_LSB] <= `CCR_MULT_8;
                    default:         ctl_q[`CCR_MULT_MSB:`CCR_MULT_LSB] <= `CCR_MULT_1;
                endcase
                ctl_q[`CCR_DIV_MSB:`CCR_DIV_LSB] <= `CCR_DIV_1;
                ctl_q[`CCR_BYPASS_BIT] <= (ratio_select_pins_i == `CCR_RATIO_RSVD);
            end else if (wr_en && wr_ok && state_q == ccr_pkg::ST_RUN) begin
                ctl_q <= (ctl_q & ~(strb_mask & `CCR_CTL_MASK)) |
                         (wr_req.data & strb_mask & `CCR_CTL_MASK);
            end
        end
    end

    // ------------------------------
    // Clock source and shared pin
    // ------------------------------
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            src_pll_q <= 1'b0;
            mult_q    <= `CCR_MULT_1;
            div_q     <= `CCR_DIV_1;
            pin_q     <= 1'b0;
        end else if (ce_i) begin
            src_pll_q <= !ctl_q[`CCR_BYPASS_BIT];
            mult_q    <= ctl_q[`CCR_MULT_MSB:`CCR_MULT_LSB];
            div_q     <= ctl_q[`CCR_DIV_MSB:`CCR_DIV_LSB];
            if (ctl_q[`CCR_PIN_FN_BIT]) begin
                pin_q <= pll_clock_level_i;
            end else begin
                pin_q <= core_reset_n_q;
            end
        end
    end

    // ------------------------------
    // Read mux
    // ------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_addr)
            `CCR_CTL_OFFSET: begin
                rd_data = ctl_q;
            end
            `CCR_STATUS_OFFSET: begin
                rd_data[`CCR_ST_RATIO_MSB:`CCR_ST_RATIO_LSB] = ratio_q;
                rd_data[`CCR_ST_RUN_BIT]  = (state_q == ccr_pkg::ST_RUN);
                rd_data[`CCR_ST_LOCK_BIT] = (state_q == ccr_pkg::ST_LOCK);
                rd_data[`CCR_ST_SRC_BIT]  = src_pll_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    ccr_axil_slave u_bus (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_q),
        .ce_i      (ce_i),
        .awaddr_i  (s_axi_awaddr_i),
        .awvalid_i (s_axi_awvalid_i),
        .awready_o (s_axi_awready_o),
        .wdata_i   (s_axi_wdata_i),
        .wstrb_i   (s_axi_wstrb_i),
        .wvalid_i  (s_axi_wvalid_i),
        .wready_o  (s_axi_wready_o),
        .bresp_o   (s_axi_bresp_o),
        .bvalid_o  (s_axi_bvalid_o),
        .bready_i  (s_axi_bready_i),
        .araddr_i  (s_axi_araddr_i),
        .arvalid_i (s_axi_arvalid_i),
        .arready_o (s_axi_arready_o),
        .rdata_o   (s_axi_rdata_o),
        .rresp_o   (s_axi_rresp_o),
        .rvalid_o  (s_axi_rvalid_o),
        .rready_i  (s_axi_rready_i),
        .wr_en_o   (wr_en),
        .wr_req_o  (wr_req),
        .wr_ok_i   (wr_ok),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data),
        .rd_ok_i   (rd_ok)
    );

    assign core_reset_n_o      = core_reset_n_q;
    assign fetch_start_o       = fetch_q;
    assign core_clk_from_pll_o = src_pll_q;
    assign pll_mult_o          = mult_q;
    assign pll_div_o           = div_q;
    assign reset_out_pin_o     = pin_q;

endmodule // ccr_core_clock_reset

`default_nettype wire

// [design/ccr_map.svh]
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ------------------------------
// Register offsets
// ------------------------------
`define CCR_CTL_OFFSET     4'h0
`define CCR_STATUS_OFFSET  4'h4

// ------------------------------
// Power management control fields
// ------------------------------
`define CCR_MULT_LSB       0
`define CCR_MULT_MSB       5
`define CCR_DIV_LSB        8
`define CCR_DIV_MSB        9
`define CCR_PIN_FN_BIT     12
`define CCR_BYPASS_BIT     15
`define CCR_CTL_MASK       32'h0000_933f

// ------------------------------
// Status fields
// ------------------------------
`define CCR_ST_RATIO_LSB   0
`define CCR_ST_RATIO_MSB   1
`define CCR_ST_RUN_BIT     2
`define CCR_ST_LOCK_BIT    3
`define CCR_ST_SRC_BIT     4

// ------------------------------
// Reset values and ratios
// ------------------------------
`define CCR_CTL_RESET      32'h0000_0000
`define CCR_RATIO_3_1      2'h0
`define CCR_RATIO_16_1     2'h1
`define CCR_RATIO_8_1      2'h2
`define CCR_RATIO_RSVD     2'h3
`define CCR_MULT_3         6'h03
`define CCR_MULT_16        6'h10
`define CCR_MULT_8         6'h08
`define CCR_MULT_1         6'h01
`define CCR_DIV_1          2'h0

// ------------------------------
// Timing, in reference clock cycles
// ------------------------------
`define CCR_LOCK_CYCLES    13'h1000

// ------------------------------
// Bus responses
// ------------------------------
`define CCR_RESP_OKAY      2'h0
`define CCR_RESP_SLVERR    2'h2

`endif

// [design/ccr_pkg.sv]
`default_nettype none

package ccr_pkg;

    // ------------------------------
    // Sequencer states
    // ------------------------------
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_LOCK,
        ST_RUN
    } ccr_state_type;

    // ------------------------------
    // Register write request
    // ------------------------------
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } ccr_wreq_type;

endpackage

`default_nettype wire

// [design/ccr_axil_slave.sv]
`default_nettype none

`include "ccr_map.svh"

module ccr_axil_slave (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  ce_i,
    // Write address and data
    input  wire logic [3:0]            awaddr_i,
    input  wire logic                  awvalid_i,
    output logic                       awready_o,
    input  wire logic [31:0]           wdata_i,
    input  wire logic [3:0]            wstrb_i,
    input  wire logic                  wvalid_i,
    output logic                       wready_o,
    // Write response
    output logic [1:0]                 bresp_o,
    output logic                       bvalid_o,
    input  wire logic                  bready_i,
    // Read address and data
    input  wire logic [3:0]            araddr_i,
    input  wire logic                  arvalid_i,
    output logic                       arready_o,
    output logic [31:0]                rdata_o,
    output logic [1:0]                 rresp_o,
    output logic                       rvalid_o,
    input  wire logic                  rready_i,
    // Register side
    output logic                       wr_en_o,
    output ccr_pkg::ccr_wreq_type      wr_req_o,
    input  wire logic                  wr_ok_i,
    output logic [3:0]                 rd_addr_o,
    input  wire logic [31:0]           rd_data_i,
    input  wire logic                  rd_ok_i
);

    logic                  aw_rdy_q;
    logic                  w_rdy_q;
    logic                  ar_rdy_q;
    logic                  bvalid_q;
    logic                  rvalid_q;
    logic [1:0]            bresp_q;
    logic [1:0]            rresp_q;
    logic [31:0]           rdata_q;
    logic [3:0]            awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  do_write;

    // ------------------------------
    // Write channels
    // ------------------------------
    assign do_write = ce_i && !aw_rdy_q && !w_rdy_q && !bvalid_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_rdy_q <= 1'b1;
            awaddr_q <= 4'h0;
        end else if (ce_i) begin
            if (aw_rdy_q && awvalid_i) begin
                aw_rdy_q <= 1'b0;
                awaddr_q <= awaddr_i;
            end else if (bvalid_q && bready_i) begin
                aw_rdy_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_rdy_q <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (ce_i) begin
            if (w_rdy_q && wvalid_i) begin
                w_rdy_q <= 1'b0;
                wdata_q <= wdata_i;
                wstrb_q <= wstrb_i;
            end else if (bvalid_q && bready_i) begin
                w_rdy_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `CCR_RESP_OKAY;
        end else if (ce_i) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok_i ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
            end else if (bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------
    // Read channels
    // ------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `CCR_RESP_OKAY;
        end else if (ce_i) begin
            if (ar_rdy_q && arvalid_i) begin
                ar_rdy_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q  <= rd_ok_i ? rd_data_i : 32'h0000_0000;
                rresp_q  <= rd_ok_i ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
            end else if (rvalid_q && rready_i) begin
                ar_rdy_q <= 1'b1;
                rvalid_q <= 1'b0;
            end
        end
    end

    assign wr_en_o       = do_write;
    assign wr_req_o.addr = awaddr_q;
    assign wr_req_o.data = wdata_q;
    assign wr_req_o.strb = wstrb_q;
    assign rd_addr_o     = araddr_i;
    assign awready_o     = aw_rdy_q;
    assign wready_o      = w_rdy_q;
    assign arready_o     = ar_rdy_q;
    assign bvalid_o      = bvalid_q;
    assign bresp_o       = bresp_q;
    assign rvalid_o      = rvalid_q;
    assign rresp_o       = rresp_q;
    assign rdata_o       = rdata_q;

endmodule // ccr_axil_slave

`default_nettype wire

// [bench/ccr_core_clock_reset_checker.sv]
`default_nettype none

module ccr_core_clock_reset_checker (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        ce_i,
    // Pins and core
    input wire logic [1:0]  ratio_select_pins_i,
    input wire logic        pll_clock_level_i,
    input wire logic        core_reset_n_o,
    input wire logic        fetch_start_o,
    input wire logic        core_clk_from_pll_o,
    input wire logic [5:0]  pll_mult_o,
    input wire logic [1:0]  pll_div_o,
    input wire logic        reset_out_pin_o,
    // Write channels
    input wire logic [3:0]  s_axi_awaddr_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0]  s_axi_wstrb_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o
);
    localparam int LOCK_EDGES = 4099;
    logic [12:0] lock_cnt_q;
    logic [3:0]  aw_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        bv_q;
    logic        fn_q;

    localparam logic [5:0] MULTS [4] = '{6'h03, 6'h10, 6'h08, 6'h01};

    // ------------------------------
    // Helper logic
    // ------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) lock_cnt_q <= 13'h0;
        else if (core_reset_n_o) lock_cnt_q <= 13'h0;
        else if (ce_i) lock_cnt_q <= lock_cnt_q + 13'h1;
    end

    always_ff @(posedge clk_i) begin
        bv_q <= s_axi_bvalid_o;
        if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            wd_q <= s_axi_wdata_i;
            ws_q <= s_axi_wstrb_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) fn_q <= 1'b0;
        else if (s_axi_bvalid_o && !bv_q && s_axi_bresp_o == 2'h0 && aw_q[3:2] == 2'h0
                 && ws_q[1] && core_reset_n_o) fn_q <= wd_q[12];
    end

    // ------------------------------
    // Properties
    // ------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_ctl_write;
        s_axi_bvalid_o && !bv_q && s_axi_bresp_o == 2'h0 && aw_q[3:2] == 2'h0
            && ws_q == 4'hf && core_reset_n_o;
    endsequence
    sequence s_release;
        fetch_start_o && !reset_out_pin_o ##1 reset_out_pin_o && !fetch_start_o;
    endsequence

    property p_lock_count;
        $rose(core_reset_n_o) |-> lock_cnt_q == LOCK_EDGES;
    endproperty
    property p_release;
        $rose(core_reset_n_o) |-> s_release;
    endproperty
    property p_start_freq;
        $rose(core_reset_n_o) |-> pll_mult_o == MULTS[ratio_select_pins_i]
            && pll_div_o == 2'h0;
    endproperty
    property p_start_src;
        fetch_start_o |-> core_clk_from_pll_o == (ratio_select_pins_i != 2'h3);
    endproperty
    property p_bypass;
        s_ctl_write |=> core_clk_from_pll_o == !wd_q[15];
    endproperty
    property p_reprogram;
        s_ctl_write |=> pll_mult_o == wd_q[5:0] && pll_div_o == wd_q[9:8];
    endproperty
    property p_clock_fn;
        fn_q && $stable(fn_q) |-> reset_out_pin_o == $past(pll_clock_level_i);
    endproperty
    property p_reset_hold;
        !core_reset_n_o |-> !reset_out_pin_o && !fetch_start_o;
    endproperty
    property p_reset_run;
        !fn_q && $stable(fn_q) && core_reset_n_o && $past(core_reset_n_o) |-> reset_out_pin_o;
    endproperty

    a_lock_count: assert property (p_lock_count) else $error("lock wait length wrong");
    a_release: assert property (p_release) else $error("core release order wrong");
    a_start_freq: assert property (p_start_freq) else $error("start multiplier wrong");
    a_start_src: assert property (p_start_src) else $error("start clock source wrong");
    a_bypass: assert property (p_bypass) else $error("bypass not applied");
    a_reprogram: assert property (p_reprogram) else $error("multiplier not applied");
    a_clock_fn: assert property (p_clock_fn) else $error("pin not showing clock");
    a_reset_hold: assert property (p_reset_hold) else $error("pin high in reset");
    a_reset_run: assert property (p_reset_run) else $error("pin low while running");
endmodule // ccr_core_clock_reset_checker

bind ccr_core_clock_reset ccr_core_clock_reset_checker i_ccr_core_clock_reset_checker (.*);

`default_nettype wire

// [bench/ccr_ext_partner.sv]
`default_nettype none

module ccr_ext_partner (
    // Bench requests
    input wire logic [1:0]  ratio_i,
    input wire logic        rst_req_i,
    // Pins toward the device
    output logic            clk_o,
    output logic            reset_n_o,
    output logic [1:0]      ratio_select_pins_o,
    output logic            pll_clock_level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold = 10;

    initial begin
        clk_o = 1'b0;
        reset_n_o = 1'b0;
        ratio_select_pins_o = 2'h0;
        pll_clock_level_o = 1'b0;
    end

    always #25 clk_o = ~clk_o;

    always @(posedge clk_o) begin
        if (rst_req_i) hold <= 10;
        else if (hold != 0) hold <= hold - 1;
        reset_n_o <= (hold == 0) && !rst_req_i;
        ratio_select_pins_o <= ratio_i;
        pll_clock_level_o <= ~pll_clock_level_o;
    end
endmodule // ccr_ext_partner

`default_nettype wire

// [bench/test_core_clock_reset_control.sv]
`default_nettype none

`include "ccr_map.svh"

module test_core_clock_reset_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, ce, pll_lvl, rst_req, lv;
    logic [1:0]  pins, ratio, div, bresp, rresp;
    logic        core_rst_n, fetch, from_pll, rst_out;
    logic [5:0]  mult;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          errors, cmp_count;
    int          cyc = 0;

    ccr_ext_partner i_ccr_ext_partner (.ratio_i(ratio), .rst_req_i(rst_req), .clk_o(clk),
        .reset_n_o(rst_n), .ratio_select_pins_o(pins), .pll_clock_level_o(pll_lvl));

    ccr_core_clock_reset i_ccr_core_clock_reset (.clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
        .ratio_select_pins_i(pins), .pll_clock_level_i(pll_lvl), .core_reset_n_o(core_rst_n),
        .fetch_start_o(fetch), .core_clk_from_pll_o(from_pll), .pll_mult_o(mult),
        .pll_div_o(div), .reset_out_pin_o(rst_out), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));

    always @(posedge clk) cyc++;

    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er,
                             input string nm);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (n == 100) errors++;
        check(nm, {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er,
                            input string nm);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        if (n == 100) errors++;
        check(nm, rdata, ed);
        check(nm, {30'h0, rresp}, {30'h0, er});
    endtask

    task automatic startup(input logic [1:0] r);
        int t0;
        logic [5:0] mt [4] = '{6'h03, 6'h10, 6'h08, 6'h01};
        @(posedge clk);
        ratio <= r;
        rst_req <= 1'b1;
        @(posedge clk);
        rst_req <= 1'b0;
        @(posedge rst_n);
        t0 = cyc;
        if (r == 2'h0) begin
            repeat (2) @(posedge clk);
            axi_write(`CCR_CTL_OFFSET, 32'h0000_1005, 2'h0, "early write");
        end
        while (fetch !== 1'b1 && cyc - t0 < 5000) begin
            @(posedge clk);
            #1;
        end
        check("lock wait", cyc - t0, 32'd4099);
        check("core reset", {31'h0, core_rst_n}, 32'h1);
        check("pin at release", {31'h0, rst_out}, 32'h0);
        check("multiplier", {26'h0, mult}, {26'h0, mt[r]});
        check("clock source", {31'h0, from_pll}, {31'h0, r != 2'h3});
        check("divider", {30'h0, div}, 32'h0);
        @(posedge clk);
        #1;
        check("reset pin", {31'h0, rst_out}, 32'h1);
        check("fetch pulse", {31'h0, fetch}, 32'h0);
        axi_read(`CCR_STATUS_OFFSET, {27'h0, r != 2'h3, 2'h1, r}, 2'h0, "status");
        axi_read(`CCR_CTL_OFFSET, {16'h0, r == 2'h3, 9'h0, mt[r]}, 2'h0, "control");
        $display("test startup %0d done", r);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        ce = 1'b1;
        rst_req = 1'b0;
        ratio = 2'h0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = 49'h0;
        errors = 0;
        cmp_count = 0;
        for (int r = 0; r < 4; r++) startup(2'(r));
        axi_write(`CCR_CTL_OFFSET, 32'h0000_820a, 2'h0, "reprogram");
        @(posedge clk);
        #1;
        check("new multiplier", {26'h0, mult}, 32'h0a);
        check("new divider", {30'h0, div}, 32'h2);
        check("bypass source", {31'h0, from_pll}, 32'h0);
        axi_write(`CCR_CTL_OFFSET, 32'h0000_0210, 2'h0, "pll again");
        @(posedge clk);
        #1;
        check("pll source", {31'h0, from_pll}, 32'h1);
        $display("test reprogram done");
        axi_write(`CCR_CTL_OFFSET, 32'hffff_ffff, 2'h0, "fill");
        axi_read(`CCR_CTL_OFFSET, 32'h0000_933f, 2'h0, "mask");
        @(posedge clk);
        #1;
        for (int i = 0; i < 6; i++) begin
            lv = pll_lvl;
            @(posedge clk);
            #1;
            check("clock pin", {31'h0, rst_out}, {31'h0, lv});
        end
        axi_write(`CCR_CTL_OFFSET, 32'h0000_0003, 2'h0, "pin back");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            #1;
            check("reset pin back", {31'h0, rst_out}, 32'h1);
        end
        $display("test pin function done");
        axi_read(4'h8, 32'h0, 2'h2, "unmapped read");
        axi_write(4'h8, 32'h0000_1000, 2'h2, "unmapped write");
        axi_write(`CCR_STATUS_OFFSET, 32'h0, 2'h2, "status write");
        axi_read(`CCR_STATUS_OFFSET, 32'h0000_0017, 2'h0, "status kept");
        $display("test refusals done");
        test_done();
    end

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        test_done();
    end
endmodule // test_core_clock_reset_control

`default_nettype wire
